/* inc/adcc_pkg.sv */
// Package: constants, state codes and carriers of the converter cycle controller
package adcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, all times in microseconds, counts derived from the system clock
  localparam int unsigned SYS_CLK_MHZ    = 100;
  localparam int unsigned T_CONV_SLOW_US = 4800;
  localparam int unsigned T_CONV_FAST_US = 1200;
  localparam int unsigned T_POR_US       = 500;
  localparam int unsigned T_REF_US       = 12000;
  localparam int unsigned CONV_SLOW_CYC  = T_CONV_SLOW_US * SYS_CLK_MHZ;
  localparam int unsigned CONV_FAST_CYC  = T_CONV_FAST_US * SYS_CLK_MHZ;
  localparam int unsigned POR_CYC        = T_POR_US * SYS_CLK_MHZ;
  localparam int unsigned REF_CYC        = T_REF_US * SYS_CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Widths, addresses, codes
  localparam int CNT_W = 21;
  localparam int RES_W = 16;
  localparam int RAW_W = 18;
  localparam logic [6:0] ADDR_STRAP_LO = 7'h14;
  localparam logic [6:0] ADDR_STRAP_HI = 7'h54;
  localparam logic [RES_W-1:0] CODE_MIN = 16'h0000;
  localparam logic [RES_W-1:0] CODE_MAX = 16'hffff;
  localparam logic [RAW_W:0] CODE_MAX_W = 19'h0ffff;
  localparam logic [RAW_W:0] DIFF_OFFSET = 19'h0ffff;
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Serial bit positions
  localparam logic [4:0] ADDR_LAST   = 5'h07;
  localparam logic [4:0] WR_LAST     = 5'h03;
  localparam logic [4:0] RD_TOP      = 5'h0f;
  localparam logic [4:0] RD_ACK_SLOT = 5'h08;
  localparam logic [4:0] RD_LAST     = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Programming word
  localparam logic KEY_FIRST_ON  = 1'b1;
  localparam logic KEY_SECOND_ON = 1'b0;
  localparam logic RATE_RST      = 1'b0;
  localparam logic SLEEP_RST     = 1'b0;

  typedef struct packed {
    logic program_key_first;
    logic program_key_second;
    logic output_rate_select;
    logic reference_powerdown_select;
  } adcc_prog_t;

  typedef enum logic [3:0] {
    ST_CONVERT = 4'h1,
    ST_NAP     = 4'h2,
    ST_SLEEP   = 4'h4,
    ST_DATAIO  = 4'h8
  } adcc_state_t;

  typedef enum logic [4:0] {
    PH_ADDR  = 5'h01,
    PH_ACK   = 5'h02,
    PH_READ  = 5'h04,
    PH_WRITE = 5'h08,
    PH_IDLE  = 5'h10
  } adcc_phase_t;

endpackage

/* logic/adcc_code_clamp.sv */
// Output code scaling and clamping for both input variants
`timescale 1ns/1ps
`default_nettype none

module adcc_code_clamp (
  input  wire logic signed [adcc_pkg::RAW_W-1:0] raw_value, // Modulator value
  input  wire logic                              diff_sel,  // Differential variant
  output logic        [adcc_pkg::RES_W-1:0]      code       // Clamped code
);

  logic signed [adcc_pkg::RAW_W:0] wide;

  // Differential: value plus full scale, halved, then clamp both ends
  always_comb begin
    wide = {raw_value[adcc_pkg::RAW_W-1], raw_value};
    if (diff_sel) begin
      wide = (wide + $signed(adcc_pkg::DIFF_OFFSET)) >>> 1;
    end
    if (wide < 0) begin
      code = adcc_pkg::CODE_MIN;
    end else if (wide > $signed(adcc_pkg::CODE_MAX_W)) begin
      code = adcc_pkg::CODE_MAX;
    end else begin
      code = wide[adcc_pkg::RES_W-1:0];
    end
  end

endmodule // adcc_code_clamp

`default_nettype wire

/* logic/adcc_link.sv */
// Serial slave engine running on the bus clock
`timescale 1ns/1ps
`default_nettype none

module adcc_link (
  input  wire logic                          scl_clk,      // Bus clock from master
  input  wire logic                          sys_rst,      // Device reset
  input  wire logic                          frame_clr,    // Start or stop seen
  input  wire logic                          sda_in,       // Data line level
  input  wire logic                          addr_strap,   // Address strap pin
  input  wire logic                          ready_lvl,    // Conversion complete
  input  wire logic [adcc_pkg::RES_W-1:0]    result,       // Held result word
  output logic                               sda_oe,       // Pull data line low
  output logic                               ack_tgl,      // Address acknowledged
  output logic                               rd_tgl,       // Sixteen bits read
  output logic                               wr_tgl,       // Input word taken
  output adcc_pkg::adcc_prog_t               wr_word       // Input word
);

  logic [1:0]           s1_q;
  logic [1:0]           s2_q;
  adcc_pkg::adcc_phase_t phase_q, phase_d;
  logic [4:0]           cnt_q, cnt_d;
  logic [7:0]           shift_q, shift_d;
  logic                 rw_q, rw_d;
  logic                 ack_ev, rd_ev, wr_ev;
  logic                 oe_d;
  logic [3:0]           bit_idx;
  logic [6:0]           own_addr;
  logic                 frame_rst;

  assign frame_rst = sys_rst | frame_clr;

  // Strap and ready come from other domains: two flops each
  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
    end else begin
      s1_q <= {addr_strap, ready_lvl};
      s2_q <= s1_q;
    end
  end

  assign own_addr = s2_q[1] ? adcc_pkg::ADDR_STRAP_HI : adcc_pkg::ADDR_STRAP_LO;

  // Bits are taken on rising edges only
  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q + 5'h01;
    shift_d = {shift_q[6:0], sda_in};
    rw_d    = rw_q;
    ack_ev  = 1'b0;
    rd_ev   = 1'b0;
    wr_ev   = 1'b0;
    case (phase_q)
      adcc_pkg::PH_ADDR: begin
        if (cnt_q == adcc_pkg::ADDR_LAST) begin
          cnt_d = 5'h00;
          if (shift_d[7:1] == own_addr && s2_q[0]) begin
            phase_d = adcc_pkg::PH_ACK;
            rw_d    = shift_d[0];
          end else begin
            phase_d = adcc_pkg::PH_IDLE; // Line stays released: refusal
          end
        end
      end
      adcc_pkg::PH_ACK: begin
        cnt_d   = 5'h00;
        ack_ev  = 1'b1;
        phase_d = rw_q ? adcc_pkg::PH_READ : adcc_pkg::PH_WRITE;
      end
      adcc_pkg::PH_READ: begin
        if (cnt_q == adcc_pkg::RD_LAST) begin
          phase_d = adcc_pkg::PH_IDLE;
          rd_ev   = 1'b1;
        end
      end
      adcc_pkg::PH_WRITE: begin
        if (cnt_q == adcc_pkg::WR_LAST) begin
          phase_d = adcc_pkg::PH_IDLE;
          wr_ev   = 1'b1;
        end
      end
      adcc_pkg::PH_IDLE: cnt_d = cnt_q;
      default:           phase_d = adcc_pkg::PH_IDLE;
    endcase
  end

  // Frame state restarts on every start or stop
  always_ff @(posedge scl_clk or posedge frame_rst) begin
    if (frame_rst) begin
      phase_q <= adcc_pkg::PH_ADDR;
      cnt_q   <= 5'h00;
      shift_q <= 8'h00;
      rw_q    <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      rw_q    <= rw_d;
    end
  end

  // Event toggles survive frame clears so no false edge is seen
  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_tgl <= 1'b0;
      rd_tgl  <= 1'b0;
      wr_tgl  <= 1'b0;
      wr_word <= '0;
    end else begin
      ack_tgl <= ack_tgl ^ ack_ev;
      rd_tgl  <= rd_tgl ^ rd_ev;
      wr_tgl  <= wr_tgl ^ wr_ev;
      if (wr_ev) begin
        wr_word <= shift_d[3:0];
      end
    end
  end

  // Result goes out most significant bit first, gap for master acknowledge
  always_comb begin
    bit_idx = (cnt_q < adcc_pkg::RD_ACK_SLOT) ? 4'(adcc_pkg::RD_TOP - cnt_q)
                                              : 4'(adcc_pkg::RD_LAST - cnt_q);
    case (phase_q)
      adcc_pkg::PH_ACK:  oe_d = 1'b1;
      adcc_pkg::PH_READ: oe_d = (cnt_q != adcc_pkg::RD_ACK_SLOT) && !result[bit_idx];
      default:           oe_d = 1'b0;
    endcase
  end

  // Outgoing bits change on falling edges only
  always_ff @(negedge scl_clk or posedge frame_rst) begin
    if (frame_rst) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= oe_d;
    end
  end

endmodule // adcc_link

`default_nettype wire

/* logic/adcc_cycle_ctrl.sv */
// Top of the converter cycle controller: power, timing and result holding
`timescale 1ns/1ps
`default_nettype none

module adcc_cycle_ctrl #(
  parameter int unsigned CONV_SLOW_CYC = adcc_pkg::CONV_SLOW_CYC, // Slow conversion cycles
  parameter int unsigned CONV_FAST_CYC = adcc_pkg::CONV_FAST_CYC, // Fast conversion cycles
  parameter int unsigned POR_CYC       = adcc_pkg::POR_CYC,       // Power-on reset hold
  parameter int unsigned REF_CYC       = adcc_pkg::REF_CYC        // Reference settling
) (
  input  wire logic                               sys_clk,                    // System clock
  input  wire logic                               sys_rst,                    // Async reset
  input  wire logic                               clk_en,                     // Clock enable
  input  wire logic                               scl_clk,                    // Bus clock pin
  input  wire logic                               sda_in,                     // Data line level
  output logic                                    sda_out,                    // Data drive level
  output logic                                    sda_oe,                     // Data pull enable
  input  wire logic                               bus_address_strap,          // Address strap
  input  wire logic                               supply_low,                 // Supply monitor
  input  wire logic                               diff_variant,               // Differential part
  input  wire logic [adcc_pkg::RAW_W-1:0]         mod_value,                  // Modulator value
  output logic                                    conv_power,                 // Converter on
  output logic                                    ref_power,                  // Reference on
  output logic                                    ref_settled,                // Reference ready
  output logic                                    output_rate_select,         // Latched rate
  output logic                                    reference_powerdown_select, // Latched sleep
  output adcc_pkg::adcc_state_t                   cycle_state,                // Cycle state
  output logic [adcc_pkg::RES_W-1:0]              result_word                 // Held result
);

  localparam int CW = adcc_pkg::CNT_W;
  localparam int NS = 7 + adcc_pkg::RAW_W;
  localparam int I_SCL = 0;
  localparam int I_SDA = 1;
  localparam int I_SUP = 2;
  localparam int I_ACK = 3;
  localparam int I_RD  = 4;
  localparam int I_WR  = 5;
  localparam int I_DIF = 6;
  localparam int I_MOD = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [NS-1:0]              sync_in;
  logic [NS-1:0]              s1_q;
  logic [NS-1:0]              s2_q;
  logic [NS-1:0]              s3_q;
  logic                       ack_tgl, rd_tgl, wr_tgl;
  adcc_pkg::adcc_prog_t       wr_word;
  logic                       link_oe;
  logic [adcc_pkg::RES_W-1:0] code;
  logic                       start_ev, stop_ev;
  logic                       ack_ev, rd_ev, wr_ev;
  logic                       prog_ok;
  logic [CW-1:0]              conv_term;
  logic [CW-1:0]              por_cnt_q, por_cnt_d;
  logic                       por_busy_q, por_busy_d;
  adcc_pkg::adcc_state_t      state_q, state_d;
  logic [CW-1:0]              conv_cnt_q, conv_cnt_d;
  logic [adcc_pkg::RES_W-1:0] result_q, result_d;
  logic                       rate_q, rate_d;
  logic                       sleep_q, sleep_d;
  logic                       ref_pwr_q, ref_pwr_d;
  logic [CW-1:0]              ref_cnt_q, ref_cnt_d;
  logic                       ref_ok_q, ref_ok_d;
  logic                       link_clr_q, link_clr_d;
  logic                       ready_q, ready_d;
  logic                       conv_pwr_q, conv_pwr_d;
  logic                       sda_oe_q;
  logic                       sda_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin and cross-domain synchronisers

  assign sync_in = {mod_value, diff_variant, wr_tgl, rd_tgl, ack_tgl, supply_low, sda_in,
                    scl_clk};

  // Two flops per bit; a third only for edge detection off the second.
  // The modulator word is quasi-static and is taken only at conversion end.
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else if (clk_en) begin
          s1_q[gi] <= sync_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  // Start: data falls while clock high; stop: data rises while clock high
  assign start_ev = s2_q[I_SCL] && s3_q[I_SCL] && s3_q[I_SDA] && !s2_q[I_SDA];
  assign stop_ev  = s2_q[I_SCL] && s3_q[I_SCL] && !s3_q[I_SDA] && s2_q[I_SDA];
  assign ack_ev   = s2_q[I_ACK] ^ s3_q[I_ACK];
  assign rd_ev    = s2_q[I_RD] ^ s3_q[I_RD];
  assign wr_ev    = s2_q[I_WR] ^ s3_q[I_WR];

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine and code clamp

  adcc_link u_link (
    .scl_clk    (scl_clk),
    .sys_rst    (sys_rst),
    .frame_clr  (link_clr_q),
    .sda_in     (sda_in),
    .addr_strap (bus_address_strap),
    .ready_lvl  (ready_q),
    .result     (result_q),
    .sda_oe     (link_oe),
    .ack_tgl    (ack_tgl),
    .rd_tgl     (rd_tgl),
    .wr_tgl     (wr_tgl),
    .wr_word    (wr_word)
  );

  adcc_code_clamp u_clamp (
    .raw_value (s2_q[NS-1:I_MOD]),
    .diff_sel  (s2_q[I_DIF]),
    .code      (code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power-on reset hold

  // Any low-supply sample restarts the hold count
  always_comb begin
    por_cnt_d  = por_cnt_q;
    por_busy_d = por_busy_q;
    if (s2_q[I_SUP]) begin
      por_cnt_d  = CW'(POR_CYC - 1);
      por_busy_d = 1'b1;
    end else if (por_cnt_q != '0) begin
      por_cnt_d = por_cnt_q - CW'(1);
    end else begin
      por_busy_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_cnt_q  <= CW'(POR_CYC - 1);
      por_busy_q <= 1'b1;
    end else if (clk_en) begin
      por_cnt_q  <= por_cnt_d;
      por_busy_q <= por_busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state machine

  assign conv_term = rate_q ? CW'(CONV_FAST_CYC - 1) : CW'(CONV_SLOW_CYC - 1);
  assign prog_ok = (wr_word.program_key_first == adcc_pkg::KEY_FIRST_ON) &&
                   (wr_word.program_key_second == adcc_pkg::KEY_SECOND_ON);

  // Bus events only move the machine outside the convert state
  always_comb begin
    state_d    = state_q;
    conv_cnt_d = conv_cnt_q;
    result_d   = result_q;
    rate_d     = rate_q;
    sleep_d    = sleep_q;
    ref_pwr_d  = ref_pwr_q;
    ref_cnt_d  = (ref_cnt_q != '0) ? ref_cnt_q - CW'(1) : ref_cnt_q;
    ref_ok_d   = ref_pwr_q && (ref_cnt_q == '0);
    link_clr_d = start_ev || stop_ev;
    if (por_busy_q) begin
      // Hold state, count, result and selects cleared, reference powered; a conversion follows the release
      state_d    = adcc_pkg::ST_CONVERT;
      conv_cnt_d = '0;
      result_d   = adcc_pkg::RESULT_RST;
      rate_d     = adcc_pkg::RATE_RST;
      sleep_d    = adcc_pkg::SLEEP_RST;
      ref_pwr_d  = 1'b1;
      ref_cnt_d  = CW'(REF_CYC - 1);
      ref_ok_d   = 1'b0;
    end else begin
      case (state_q)
        adcc_pkg::ST_CONVERT: begin
          if (conv_cnt_q >= conv_term) begin
            result_d = code;
            state_d  = sleep_q ? adcc_pkg::ST_SLEEP : adcc_pkg::ST_NAP;
            if (sleep_q) begin
              ref_pwr_d = 1'b0;
              ref_ok_d  = 1'b0;
            end
          end else begin
            conv_cnt_d = conv_cnt_q + CW'(1);
          end
        end
        adcc_pkg::ST_NAP, adcc_pkg::ST_SLEEP: begin
          if (ack_ev) begin
            state_d = adcc_pkg::ST_DATAIO;
            if (!ref_pwr_q) begin
              ref_pwr_d = 1'b1;
              ref_cnt_d = CW'(REF_CYC - 1);
              ref_ok_d  = 1'b0;
            end
          end
        end
        adcc_pkg::ST_DATAIO: begin
          if (wr_ev && prog_ok) begin
            rate_d  = wr_word.output_rate_select;
            sleep_d = wr_word.reference_powerdown_select;
          end
          if (rd_ev || stop_ev) begin
            state_d    = adcc_pkg::ST_CONVERT;
            conv_cnt_d = '0;
          end
        end
        default: state_d = adcc_pkg::ST_CONVERT;
      endcase
    end
    ready_d    = (state_d != adcc_pkg::ST_CONVERT);
    conv_pwr_d = (state_d == adcc_pkg::ST_CONVERT);
  end

  // Result register loads only at conversion end and clears in the reset hold, so it stays static otherwise
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= adcc_pkg::ST_CONVERT;
      conv_cnt_q <= '0;
      result_q   <= adcc_pkg::RESULT_RST;
      rate_q     <= adcc_pkg::RATE_RST;
      sleep_q    <= adcc_pkg::SLEEP_RST;
      ref_pwr_q  <= 1'b1;
      ref_cnt_q  <= '0;
      ref_ok_q   <= 1'b0;
      link_clr_q <= 1'b0;
      ready_q    <= 1'b0;
      conv_pwr_q <= 1'b1;
    end else if (clk_en) begin
      state_q    <= state_d;
      conv_cnt_q <= conv_cnt_d;
      result_q   <= result_d;
      rate_q     <= rate_d;
      sleep_q    <= sleep_d;
      ref_pwr_q  <= ref_pwr_d;
      ref_cnt_q  <= ref_cnt_d;
      ref_ok_q   <= ref_ok_d;
      link_clr_q <= link_clr_d;
      ready_q    <= ready_d;
      conv_pwr_q <= conv_pwr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs

  // The drive level is pinned low: the line is only ever pulled down,
  // and the bus clock is never an output of this block.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_out_q <= 1'b0;
    end else if (clk_en) begin
      sda_out_q <= 1'b0;
    end
  end

  assign sda_oe_q = link_oe; // Falling-edge flop in the bus engine

  assign sda_out                    = sda_out_q;
  assign sda_oe                     = sda_oe_q;
  assign conv_power                 = conv_pwr_q;
  assign ref_power                  = ref_pwr_q;
  assign ref_settled                = ref_ok_q;
  assign output_rate_select         = rate_q;
  assign reference_powerdown_select = sleep_q;
  assign cycle_state                = state_q;
  assign result_word                = result_q;

endmodule // adcc_cycle_ctrl

`default_nettype wire

/* bench/adcc_cycle_ctrl_asserts.sv */
// Port checks of the converter cycle controller
`timescale 1ns/1ps
`default_nettype none
module adcc_cycle_ctrl_asserts #(
  parameter int unsigned CONV_SLOW_CYC = 200, // Slow convert cycles
  parameter int unsigned CONV_FAST_CYC = 60   // Fast convert cycles
) (
  input wire logic                  sys_clk,                    // Clock
  input wire logic                  sys_rst,                    // Reset
  input wire logic                  clk_en,                     // Enable
  input wire logic                  supply_low,                 // Supply monitor
  input wire logic                  sda_out,                    // Drive level
  input wire logic                  conv_power,                 // Converter on
  input wire logic                  ref_power,                  // Reference on
  input wire logic                  output_rate_select,         // Rate
  input wire logic                  reference_powerdown_select, // Sleep select
  input wire adcc_pkg::adcc_state_t cycle_state,                // State
  input wire logic [15:0]           result_word                 // Result
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  int unsigned cnt_d, cnt_q, lim;
  logic        first_d, first_q;
  assign lim = output_rate_select ? CONV_FAST_CYC : CONV_SLOW_CYC;
  // Enabled cycles in convert; the run after power-on also holds the reset hold
  always_comb begin
    cnt_d = (cycle_state != adcc_pkg::ST_CONVERT) ? 0 : cnt_q + 32'(clk_en);
    first_d = supply_low | (first_q & (cycle_state == adcc_pkg::ST_CONVERT));
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 0;
      first_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      first_q <= first_d;
    end
  end
  a_drain_only: assert property (!sda_out) else $error("data line driven high");
  a_conv_power: assert property (conv_power == (cycle_state == adcc_pkg::ST_CONVERT))
    else $error("converter power differs from state");
  a_nap_ref_on: assert property (cycle_state == adcc_pkg::ST_NAP |-> ref_power
    && !reference_powerdown_select) else $error("nap power wrong");
  a_sleep_ref_off: assert property (cycle_state == adcc_pkg::ST_SLEEP |-> !ref_power
    && reference_powerdown_select) else $error("sleep power wrong");
  a_enter_pd: assert property ($changed(cycle_state) && cycle_state inside
    {adcc_pkg::ST_NAP, adcc_pkg::ST_SLEEP} |-> $past(cycle_state) == adcc_pkg::ST_CONVERT)
    else $error("power-down not after convert");
  a_enter_data: assert property ($changed(cycle_state) && cycle_state == adcc_pkg::ST_DATAIO
    |-> $past(cycle_state) inside {adcc_pkg::ST_NAP, adcc_pkg::ST_SLEEP})
    else $error("data state not after power-down");
  a_result_hold: assert property (!supply_low && cycle_state == $past(cycle_state)
    && cycle_state inside {adcc_pkg::ST_NAP, adcc_pkg::ST_SLEEP} |-> $stable(result_word))
    else $error("held result changed");
  a_conv_length: assert property ($past(cycle_state) == adcc_pkg::ST_CONVERT && !first_q
    && cycle_state != adcc_pkg::ST_CONVERT |-> cnt_q + 1 >= lim && cnt_q <= lim + 1)
    else $error("conversion length wrong");
  a_ref_wake: assert property ($past(cycle_state) == adcc_pkg::ST_SLEEP
    && cycle_state == adcc_pkg::ST_DATAIO |-> ##[0:4] ref_power) else $error("reference asleep");
endmodule // adcc_cycle_ctrl_asserts
bind adcc_cycle_ctrl adcc_cycle_ctrl_asserts #(.CONV_SLOW_CYC(CONV_SLOW_CYC),
  .CONV_FAST_CYC(CONV_FAST_CYC)) adcc_cycle_ctrl_asserts_inst (.sys_clk, .sys_rst, .clk_en,
  .supply_low, .sda_out, .conv_power, .ref_power, .output_rate_select,
  .reference_powerdown_select, .cycle_state, .result_word);
`default_nettype wire

/* bench/adcc_i2c_master.sv */
// Bus master model: makes the serial clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module adcc_i2c_master (
  input  wire logic link_clk, // Base tick, serial clock derived from it
  input  wire logic sda_in,   // Resolved data line
  output var  logic scl,      // Serial clock, still high between frames
  output var  logic sda_pull  // High while pulling data low
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // Data moves while the clock is low, is read while it is high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda_in;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  // Long start hold lets the slow side see the start; stop ends every frame
  task automatic frame(input logic [6:0] adr, input logic rd, input logic [3:0] wr,
                       output logic ack, output logic [15:0] dat);
    logic       r;
    logic [7:0] hdr;
    hdr = {adr, rd};
    dat = 16'h0000;
    sda_pull = 1'b1;
    tick(20);
    scl = 1'b0;
    tick(4);
    for (int i = 7; i >= 0; i--) bit_io(hdr[i], r);
    bit_io(1'b1, r);
    ack = !r;
    for (int i = 0; i < 17 && ack && rd; i++) begin
      bit_io(i != 8, r); // Master acknowledges the high byte
      if (i != 8) dat = {dat[14:0], r};
    end
    for (int i = 3; i >= 0 && ack && !rd; i--) bit_io(wr[i], r);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(20);
    sda_pull = 1'b0;
    tick(20);
  endtask
endmodule // adcc_i2c_master
`default_nettype wire

/* bench/adcc_cycle_ctrl_tb_top.sv */
// Self-checking bench of the converter cycle controller
`timescale 1ns/1ps
`default_nettype none
module adcc_cycle_ctrl_tb_top;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, link_clk = 1'b0;
  logic bus_address_strap = 1'b0, supply_low = 1'b0, diff_variant = 1'b0;
  logic [17:0] mod_value = 18'h00000;
  logic scl_clk, sda_pull, sda_out, sda_oe, conv_power, ref_power, ref_settled;
  logic output_rate_select, reference_powerdown_select, exp_rate = 1'b0, exp_slp = 1'b0;
  logic [15:0] result_word;
  logic [3:0]  w;
  adcc_pkg::adcc_state_t cycle_state;
  int failures = 0, n_checks = 0;
  wire logic sda_in = !(sda_pull | sda_oe); // Open-drain line with pull-up
  adcc_cycle_ctrl #(.CONV_SLOW_CYC(200), .CONV_FAST_CYC(60), .POR_CYC(20), .REF_CYC(100))
    adcc_cycle_ctrl_inst (.sys_clk, .sys_rst, .clk_en, .scl_clk, .sda_in, .sda_out, .sda_oe,
    .bus_address_strap, .supply_low, .diff_variant, .mod_value, .conv_power, .ref_power,
    .ref_settled, .output_rate_select, .reference_powerdown_select, .cycle_state, .result_word);
  adcc_i2c_master adcc_i2c_master_inst (.link_clk, .sda_in, .scl(scl_clk), .sda_pull);
  always #5 sys_clk = ~sys_clk;
  // Base tick is offset so the two clocks share no phase
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // Enable dips now and then to stretch the slow side
  always @(negedge sys_clk) clk_en <= !sys_rst && ($urandom % 8) != 0;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [15:0] exp_code(logic [17:0] m, logic d);
    logic signed [19:0] v;
    v = $signed({{2{m[17]}}, m});
    if (d) v = (v + 20'sd65535) >>> 1;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : v[15:0];
  endfunction
  function automatic logic [6:0] adr(logic s);
    return s ? adcc_pkg::ADDR_STRAP_HI : adcc_pkg::ADDR_STRAP_LO;
  endfunction
  task automatic wait_pd;
    int i;
    for (i = 0; i < 4000 && cycle_state != adcc_pkg::ST_NAP
         && cycle_state != adcc_pkg::ST_SLEEP; i++) @(negedge sys_clk);
    check(32'(i < 4000), 32'h1);
  endtask
  task automatic access(input logic [6:0] a, input logic rd, input logic ea, input logic [15:0] ed);
    logic        ack;
    logic [15:0] dat;
    adcc_i2c_master_inst.frame(a, rd, w, ack, dat);
    check(32'(ack), 32'(ea));
    if (rd && ack) check(32'(dat), 32'(ed));
  endtask
  logic [17:0] corner [6] = '{18'h3ffff, 18'h20000, 18'h1ffff, 18'h0ffff, 18'h10000, 18'h0};
  initial begin
    void'($urandom(32'hf20636a5));
    w = 4'h0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    access(adr(1'b0), 1'b1, 1'b0, 16'h0);
    wait_pd;
    access(adr(1'b1), 1'b1, 1'b0, 16'h0);
    for (int k = 0; k < 14; k++) begin
      wait_pd;
      @(negedge sys_clk);
      bus_address_strap = $urandom;
      diff_variant = (k < 6) ? k[0] : 1'($urandom);
      mod_value = (k < 6) ? corner[k] : 18'($urandom);
      w = (k < 4) ? {2'b10, k[1:0]} : 4'($urandom);
      if (w[3:2] == 2'b10) {exp_rate, exp_slp} = w[1:0];
      access(adr(bus_address_strap), 1'b0, 1'b1, 16'h0);
      check(32'({output_rate_select, reference_powerdown_select}), 32'({exp_rate, exp_slp}));
      wait_pd;
      check(32'({ref_settled, ref_power, cycle_state}), 32'({{2{!exp_slp}},
            exp_slp ? adcc_pkg::ST_SLEEP : adcc_pkg::ST_NAP}));
      access(adr(bus_address_strap), 1'b1, 1'b1, exp_code(mod_value, diff_variant));
    end
    wait_pd;
    @(negedge sys_clk) supply_low = 1'b1;
    repeat (20) @(negedge sys_clk);
    check(32'({result_word, output_rate_select, cycle_state}), 32'({17'h0, adcc_pkg::ST_CONVERT}));
    supply_low = 1'b0;
    end_sim;
  end
  initial begin
    #400000;
    failures++;
    end_sim;
  end
endmodule // adcc_cycle_ctrl_tb_top
`default_nettype wire
